// [logic/ftp_pkg.sv]
// Constants for the fault and test register page
// Overview of operation
// R1 - Decode page indices 0x00,01,03,04,05,06,1D
// R2 - Pin echo read-only; bit0 driver enable
// R3 - Busy echo high while loading from NVM
// R4 - Safety echo low on parallel shutdown
// R5 - Fault echo mirrors fault output pin
// R6 - Channel echo 0 enabled, 1 otherwise
// R7 - Self-test bit clears on completion, fail latches
// R8 - Service fault one latches monitor flags
// R9 - Digital ground loss latched, clear on read
// R10 - Analog ground loss latched, clear on read
// R11 - Fail-safe VDS fault latched, clear on read
// R12 - Power-on flag set at reset, clear on read
// R13 - Trim checksum error plain read bit
// R14 - Link timeout latch and timeout, clear on read
// R15 - Core over/undervoltage latched, clear on read
// R16 - Pump, battery, thermal latched, clear on read
// R17 - Config register monitor latched, clear on read
// R18 - Service fault two resets zero; clamp test
// R19 - Clamp monitor plain status, no clear
// R20 - Supply self-test failures latched, clear on read
// R21 - Oscillator faults latched, clear on read
// R22 - Unused bits read zero, ignore writes
package ftp_pkg;
   // ----------------------------------------------------------------
   // Page indices
   // ----------------------------------------------------------------
   localparam int          IDX_W         = 5;
   localparam int          DATA_W        = 16;
   localparam logic [4:0]  IDX_PIN_ECHO  = 5'h00;
   localparam logic [4:0]  IDX_SELFTEST  = 5'h01;
   localparam logic [4:0]  IDX_SVC_ONE   = 5'h03;
   localparam logic [4:0]  IDX_SVC_TWO   = 5'h04;
   localparam logic [4:0]  IDX_MASK_ONE  = 5'h05;
   localparam logic [4:0]  IDX_MASK_TWO  = 5'h06;
   localparam logic [4:0]  IDX_LINK_FLT  = 5'h1D;
   // ----------------------------------------------------------------
   // Pin echo fields
   // ----------------------------------------------------------------
   localparam int PE_DRV_EN  = 0;
   localparam int PE_CH_LO   = 1;
   localparam int PE_RST_PIN = 5;
   localparam int PE_FAULT   = 6;
   localparam int PE_SAFETY  = 7;
   localparam int PE_BUSY    = 8;
   localparam int ST_RUN     = 0;
   // ----------------------------------------------------------------
   // Service fault one fields
   // ----------------------------------------------------------------
   localparam int S1_DGND    = 15;
   localparam int S1_AGND    = 14;
   localparam int S1_FS_VDS  = 10;
   localparam int S1_POR     = 9;
   localparam int S1_TRIM    = 8;
   localparam int S1_TO_LAT  = 7;
   localparam int S1_TO      = 6;
   localparam int S1_CORE_OV = 5;
   localparam int S1_CORE_UV = 4;
   localparam int S1_PUMP_UV = 3;
   localparam int S1_CFG_MON = 2;
   localparam int S1_BAT_OV  = 1;
   localparam int S1_THERMAL = 0;
   // ----------------------------------------------------------------
   // Service fault two fields
   // ----------------------------------------------------------------
   localparam int S2_CLAMP_T = 15;
   localparam int S2_CLAMP_M = 14;
   localparam int S2_OV_T    = 7;
   localparam int S2_UV_T    = 6;
   localparam int S2_BAT_T   = 4;
   localparam int S2_DGND_T  = 3;
   localparam int S2_AGND_T  = 2;
   localparam int S2_DIAG_OSC = 1;
   localparam int S2_MAIN_OSC = 0;
   // ----------------------------------------------------------------
   // Reset values and bit masks
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_SELFTEST = 16'h0000;
   localparam logic [15:0] RST_SVC_ONE  = 16'h0200;
   localparam logic [15:0] RST_SVC_TWO  = 16'h0000;
   localparam logic [15:0] RST_MASK     = 16'hFFFF;
   localparam logic [15:0] RST_LINK     = 16'h0000;
   localparam logic [15:0] COR_SVC_ONE  = 16'hC6FF;
   localparam logic [15:0] COR_SVC_TWO  = 16'h80DF;
   localparam logic [15:0] USED_PIN     = 16'h01FF;
   localparam logic [15:0] USED_MASK1   = 16'hC5DF;
   localparam logic [15:0] USED_MASK2   = 16'h409F;
   localparam logic [15:0] USED_LINK    = 16'h1E00;
endpackage

// [logic/ftp_echo_if.sv]
// Synchronised pin levels for the page
`timescale 1ns/1ps
interface ftp_echo_if #(
   parameter int W = 7
);
   logic [W-1:0] level;
   modport src (output level);
   modport dst (input  level);
endinterface

// [logic/ftp_pin_sync.sv]
// Three-stage pin synchroniser
`timescale 1ns/1ps
module ftp_pin_sync #(
   parameter int W = 7
) (
   // Clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   // Raw pins
   input  wire logic [W-1:0] pin_raw,
   // Filtered levels
   ftp_echo_if.src           echo
);
   initial begin
      if (W < 1) $error("W below 1");
   end

   // ----------------------------------------------------------------
   // One synchroniser per pin
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic s1;
         logic s2;
         logic s3;
         logic held;
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               s1   <= 1'b0;
               s2   <= 1'b0;
               s3   <= 1'b0;
               held <= 1'b0;
            end else begin
               s1 <= pin_raw[i];
               s2 <= s1;
               s3 <= s2;
               // Change taken only once two stages agree
               if (s2 == s3) begin
                  held <= s3;
               end
            end
         end
         assign echo.level[i] = held;
      end
   endgenerate
endmodule

// [logic/ftp_fault_page.sv]
// Fault and test register page
`timescale 1ns/1ps
module ftp_fault_page #(
   parameter int CHANNELS = 4
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // Register port from the link decoder
   input  wire logic        reg_rd,
   input  wire logic        reg_wr,
   input  wire logic [4:0]  reg_idx,
   input  wire logic [15:0] reg_wdata,
   output logic      [15:0] reg_rdata,
   output logic             reg_rvalid,
   // External pins
   input  wire logic        driver_enable_input,
   input  wire logic [3:0]  channel_input_pin,
   input  wire logic        external_reset_pin_n,
   input  wire logic        fault_output_pin_n,
   // Internal status from the rest of the device
   input  wire logic        hw_mode,
   input  wire logic        nvm_busy,
   input  wire logic        safety_path_echo,
   input  wire logic        trim_crc_error,
   input  wire logic        clamp_monitor,
   input  wire logic [15:0] svc_one_event,
   input  wire logic [15:0] svc_two_event,
   input  wire logic [15:0] link_fault_flags,
   // Supply self-test handshake
   input  wire logic        supply_self_test_done,
   input  wire logic        supply_self_test_fail,
   output logic             supply_self_test,
   // State for fault pin mapping
   output logic      [15:0] service_fault_one,
   output logic      [15:0] service_fault_two,
   output logic      [15:0] service_fault_mask_one,
   output logic      [15:0] service_fault_mask_two
);
   localparam int PINS = CHANNELS + 3;

   initial begin
      if (CHANNELS != 4) $error("CHANNELS must be 4");
   end

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   ftp_echo_if #(.W(PINS)) echo_bus ();
   logic [PINS-1:0] pin_raw;

   assign pin_raw = {fault_output_pin_n, external_reset_pin_n,
                     channel_input_pin, driver_enable_input};

   ftp_pin_sync #(.W(PINS)) u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .pin_raw  (pin_raw),
      .echo     (echo_bus.src)
   );

   // ----------------------------------------------------------------
   // Access decode
   // ----------------------------------------------------------------
   logic rd_svc_one;
   logic rd_svc_two;
   logic wr_selftest;
   logic wr_mask_one;
   logic wr_mask_two;

   assign rd_svc_one  = reg_rd && (reg_idx == ftp_pkg::IDX_SVC_ONE); // R1
   assign rd_svc_two  = reg_rd && (reg_idx == ftp_pkg::IDX_SVC_TWO); // R1
   assign wr_selftest = reg_wr && (reg_idx == ftp_pkg::IDX_SELFTEST);
   assign wr_mask_one = reg_wr && (reg_idx == ftp_pkg::IDX_MASK_ONE);
   assign wr_mask_two = reg_wr && (reg_idx == ftp_pkg::IDX_MASK_TWO);

   // ----------------------------------------------------------------
   // Pin echo
   // ----------------------------------------------------------------
   logic [15:0] pin_echo_status;
   logic [15:0] next_pin_echo;

   always_comb begin
      next_pin_echo = 16'h0000; // R22
      next_pin_echo[ftp_pkg::PE_DRV_EN] = echo_bus.level[0]; // R2
      for (int c = 0; c < CHANNELS; c++) begin
         // Pin high enables a channel only in hardware mode
         next_pin_echo[ftp_pkg::PE_CH_LO + c] =
            !(hw_mode && echo_bus.level[1 + c]); // R6
      end
      next_pin_echo[ftp_pkg::PE_RST_PIN] = !echo_bus.level[CHANNELS + 1];
      next_pin_echo[ftp_pkg::PE_FAULT]   = echo_bus.level[CHANNELS + 2]; // R5
      next_pin_echo[ftp_pkg::PE_SAFETY]  = safety_path_echo; // R4
      next_pin_echo[ftp_pkg::PE_BUSY]    = nvm_busy; // R3
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_echo_status <= 16'h0000;
      end else begin
         pin_echo_status <= next_pin_echo; // R2
      end
   end

   // ----------------------------------------------------------------
   // On-demand supply self-test
   // ----------------------------------------------------------------
   // Writing 0 cannot abort a running test; only completion clears it
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         supply_self_test <= ftp_pkg::RST_SELFTEST[ftp_pkg::ST_RUN];
      end else if (supply_self_test && supply_self_test_done) begin
         supply_self_test <= 1'b0; // R7
      end else if (wr_selftest && reg_wdata[ftp_pkg::ST_RUN]) begin
         supply_self_test <= 1'b1; // R7
      end
   end

   // ----------------------------------------------------------------
   // Service fault one
   // ----------------------------------------------------------------
   logic [15:0] set_one;
   logic [15:0] clr_one;
   logic [15:0] next_svc_one;

   always_comb begin
      set_one = 16'h0000;
      set_one[ftp_pkg::S1_DGND]    = svc_one_event[ftp_pkg::S1_DGND]; // R9
      set_one[ftp_pkg::S1_AGND]    = svc_one_event[ftp_pkg::S1_AGND]; // R10
      set_one[ftp_pkg::S1_FS_VDS]  = svc_one_event[ftp_pkg::S1_FS_VDS]; // R11
      set_one[ftp_pkg::S1_POR]     = supply_self_test && // R12
                                     supply_self_test_done &&
                                     supply_self_test_fail; // R7
      set_one[ftp_pkg::S1_TO_LAT]  = svc_one_event[ftp_pkg::S1_TO_LAT]; // R14
      set_one[ftp_pkg::S1_TO]      = svc_one_event[ftp_pkg::S1_TO]; // R14
      set_one[ftp_pkg::S1_CORE_OV] = svc_one_event[ftp_pkg::S1_CORE_OV]; // R15
      set_one[ftp_pkg::S1_CORE_UV] = svc_one_event[ftp_pkg::S1_CORE_UV]; // R15
      set_one[ftp_pkg::S1_PUMP_UV] = svc_one_event[ftp_pkg::S1_PUMP_UV]; // R16
      set_one[ftp_pkg::S1_CFG_MON] = svc_one_event[ftp_pkg::S1_CFG_MON]; // R17
      set_one[ftp_pkg::S1_BAT_OV]  = svc_one_event[ftp_pkg::S1_BAT_OV]; // R16
      set_one[ftp_pkg::S1_THERMAL] = svc_one_event[ftp_pkg::S1_THERMAL]; // R16
      clr_one = rd_svc_one ? ftp_pkg::COR_SVC_ONE : 16'h0000;
      // New events win over the read clear so none is lost
      next_svc_one = (service_fault_one & ~clr_one) | set_one; // R8
      next_svc_one[ftp_pkg::S1_TRIM] = trim_crc_error; // R13
      next_svc_one = next_svc_one & (ftp_pkg::COR_SVC_ONE |
                     (16'h0001 << ftp_pkg::S1_TRIM)); // R22
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         service_fault_one <= ftp_pkg::RST_SVC_ONE; // R12
      end else begin
         service_fault_one <= next_svc_one;
      end
   end

   // ----------------------------------------------------------------
   // Service fault two
   // ----------------------------------------------------------------
   logic [15:0] set_two;
   logic [15:0] clr_two;
   logic [15:0] next_svc_two;

   always_comb begin
      set_two = svc_two_event & ftp_pkg::COR_SVC_TWO; // R18 R20 R21
      clr_two = rd_svc_two ? ftp_pkg::COR_SVC_TWO : 16'h0000;
      next_svc_two = (service_fault_two & ~clr_two) | set_two;
      next_svc_two[ftp_pkg::S2_CLAMP_M] = clamp_monitor; // R19
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         service_fault_two <= ftp_pkg::RST_SVC_TWO; // R18
      end else begin
         service_fault_two <= next_svc_two;
      end
   end

   // ----------------------------------------------------------------
   // Fault masks and link fault echo
   // ----------------------------------------------------------------
   logic [15:0] link_fault_echo;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         service_fault_mask_one <= ftp_pkg::RST_MASK & ftp_pkg::USED_MASK1;
      end else if (wr_mask_one) begin
         service_fault_mask_one <= reg_wdata & ftp_pkg::USED_MASK1; // R22
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         service_fault_mask_two <= ftp_pkg::RST_MASK & ftp_pkg::USED_MASK2;
      end else if (wr_mask_two) begin
         service_fault_mask_two <= reg_wdata & ftp_pkg::USED_MASK2; // R22
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         link_fault_echo <= ftp_pkg::RST_LINK;
      end else begin
         link_fault_echo <= link_fault_flags & ftp_pkg::USED_LINK;
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   logic [15:0] next_rdata;

   always_comb begin
      unique case (reg_idx)
         ftp_pkg::IDX_PIN_ECHO: next_rdata = pin_echo_status; // R1
         ftp_pkg::IDX_SELFTEST: next_rdata = {15'h0000, supply_self_test};
         ftp_pkg::IDX_SVC_ONE:  next_rdata = service_fault_one;
         ftp_pkg::IDX_SVC_TWO:  next_rdata = service_fault_two;
         ftp_pkg::IDX_MASK_ONE: next_rdata = service_fault_mask_one;
         ftp_pkg::IDX_MASK_TWO: next_rdata = service_fault_mask_two;
         ftp_pkg::IDX_LINK_FLT: next_rdata = link_fault_echo;
         default:               next_rdata = 16'h0000; // R22
      endcase
   end

   // Read data holds until the next read
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_unmapped_reads_zero: // R1
   assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_rd && reg_idx == 5'h02 |=> reg_rvalid && reg_rdata == 16'h0000)
      else $error("unmapped read nonzero");

   a_drv_enable_echo: // R2
   assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(echo_bus.level[0]) |=> pin_echo_status[0])
      else $error("enable echo stale");

   a_busy_echo: // R3
   assert property (@(posedge core_clk) disable iff (!rst_n)
      nvm_busy |=> pin_echo_status[8])
      else $error("busy echo low");

   a_channel_sw_mode: // R6
   assert property (@(posedge core_clk) disable iff (!rst_n)
      !hw_mode |=> pin_echo_status[4:1] == 4'hF)
      else $error("channel echo in sw mode");

   a_selftest_done: // R7
   assert property (@(posedge core_clk) disable iff (!rst_n)
      supply_self_test && supply_self_test_done && supply_self_test_fail
      |=> !supply_self_test && service_fault_one[9])
      else $error("self-test end missed");

   a_svc_one_clear: // R9
   assert property (@(posedge core_clk) disable iff (!rst_n)
      rd_svc_one && !svc_one_event[15] |=> !service_fault_one[15])
      else $error("ground flag not cleared");

   a_set_beats_clear: // R16
   assert property (@(posedge core_clk) disable iff (!rst_n)
      rd_svc_one && svc_one_event[0] |=> service_fault_one[0])
      else $error("thermal event lost");

   a_trim_plain: // R13
   assert property (@(posedge core_clk) disable iff (!rst_n)
      trim_crc_error ##1 (trim_crc_error && rd_svc_one)
      |=> service_fault_one[8])
      else $error("trim bit cleared");

   a_clamp_monitor: // R19
   assert property (@(posedge core_clk) disable iff (!rst_n)
      clamp_monitor |=> service_fault_two[14])
      else $error("clamp not shown");

   a_svc_two_latch: // R21
   assert property (@(posedge core_clk) disable iff (!rst_n)
      svc_two_event[1] && !rd_svc_two |=> service_fault_two[1]
      ##1 (service_fault_two[1] || $past(rd_svc_two)))
      else $error("osc flag lost");

   a_mask_unused: // R22
   assert property (@(posedge core_clk) disable iff (!rst_n)
      wr_mask_one |=> service_fault_mask_one[13:11] == 3'h0)
      else $error("unused mask bits set");
endmodule

// [tb/ftp_host_model.sv]
// Host model driving the page register port
`timescale 1ns/1ps
module ftp_host_model (
   // Clock
   input  wire logic        core_clk,
   // Register port
   output logic             reg_rd,
   output logic             reg_wr,
   output logic      [4:0]  reg_idx,
   output logic      [15:0] reg_wdata,
   input  wire logic [15:0] reg_rdata,
   input  wire logic        reg_rvalid
);
   // ----------------------------------------------------------------
   // Idle bus
   // ----------------------------------------------------------------
   initial begin
      reg_rd    = 1'b0;
      reg_wr    = 1'b0;
      reg_idx   = 5'h1F;
      reg_wdata = 16'hA5A5;
   end

   // Flip released lines so stale index and data differ from the last transfer
   task automatic release_bus();
      reg_rd    = 1'b0;
      reg_wr    = 1'b0;
      reg_idx   = ~reg_idx;
      reg_wdata = ~reg_wdata;
   endtask

   // ----------------------------------------------------------------
   // Transfers on the falling edge
   // ----------------------------------------------------------------
   task automatic wr(input logic [4:0] idx, input logic [15:0] data);
      @(negedge core_clk);
      reg_wr    = 1'b1;
      reg_idx   = idx;
      reg_wdata = data;
      @(negedge core_clk);
      release_bus();
   endtask

   task automatic rd(input logic [4:0] idx, output logic [15:0] data,
                     output logic valid);
      @(negedge core_clk);
      reg_rd  = 1'b1;
      reg_idx = idx;
      @(negedge core_clk);
      release_bus();
      valid = reg_rvalid;
      data  = reg_rdata;
   endtask
endmodule

// [tb/tb.sv]
// Bench for the fault and test register page
`timescale 1ns/1ps
module tb;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic        core_clk              = 1'b0;
   logic        rst_n                 = 1'b0;
   logic        reg_rd;
   logic        reg_wr;
   logic [4:0]  reg_idx;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic        reg_rvalid;
   logic        driver_enable_input   = 1'b0;
   logic [3:0]  channel_input_pin     = 4'h0;
   logic        external_reset_pin_n  = 1'b1;
   logic        fault_output_pin_n    = 1'b1;
   logic        hw_mode               = 1'b0;
   logic        nvm_busy              = 1'b0;
   logic        safety_path_echo      = 1'b1;
   logic        trim_crc_error        = 1'b0;
   logic        clamp_monitor         = 1'b0;
   logic [15:0] svc_one_event         = 16'h0000;
   logic [15:0] svc_two_event         = 16'h0000;
   logic [15:0] link_fault_flags      = 16'h0000;
   logic        supply_self_test_done = 1'b0;
   logic        supply_self_test_fail = 1'b0;
   logic        supply_self_test;
   logic [15:0] service_fault_one;
   logic [15:0] service_fault_two;
   logic [15:0] service_fault_mask_one;
   logic [15:0] service_fault_mask_two;
   int          n_mismatch            = 0;
   int          compares              = 0;

   always #4 core_clk = ~core_clk;

   ftp_host_model ftp_host_model_inst (
      .core_clk   (core_clk),
      .reg_rd     (reg_rd),
      .reg_wr     (reg_wr),
      .reg_idx    (reg_idx),
      .reg_wdata  (reg_wdata),
      .reg_rdata  (reg_rdata),
      .reg_rvalid (reg_rvalid)
   );

   ftp_fault_page #(.CHANNELS(4)) ftp_fault_page_inst (
      .core_clk               (core_clk),
      .rst_n                  (rst_n),
      .reg_rd                 (reg_rd),
      .reg_wr                 (reg_wr),
      .reg_idx                (reg_idx),
      .reg_wdata              (reg_wdata),
      .reg_rdata              (reg_rdata),
      .reg_rvalid             (reg_rvalid),
      .driver_enable_input    (driver_enable_input),
      .channel_input_pin      (channel_input_pin),
      .external_reset_pin_n   (external_reset_pin_n),
      .fault_output_pin_n     (fault_output_pin_n),
      .hw_mode                (hw_mode),
      .nvm_busy               (nvm_busy),
      .safety_path_echo       (safety_path_echo),
      .trim_crc_error         (trim_crc_error),
      .clamp_monitor          (clamp_monitor),
      .svc_one_event          (svc_one_event),
      .svc_two_event          (svc_two_event),
      .link_fault_flags       (link_fault_flags),
      .supply_self_test_done  (supply_self_test_done),
      .supply_self_test_fail  (supply_self_test_fail),
      .supply_self_test       (supply_self_test),
      .service_fault_one      (service_fault_one),
      .service_fault_two      (service_fault_two),
      .service_fault_mask_one (service_fault_mask_one),
      .service_fault_mask_two (service_fault_mask_two)
   );

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic rd_chk(input logic [4:0] idx, input logic [15:0] exp,
                         input string what);
      logic [15:0] data;
      logic        valid;
      ftp_host_model_inst.rd(idx, data, valid);
      check("rvalid", {15'h0000, valid}, 16'h0001);
      check(what, data, exp);
   endtask

   task automatic pulse(input bit two, input int b);
      @(negedge core_clk);
      if (two) svc_two_event[b] = 1'b1;
      else svc_one_event[b] = 1'b1;
      @(negedge core_clk);
      svc_one_event = 16'h0000;
      svc_two_event = 16'h0000;
   endtask

   task automatic flag_cycle(input bit two, input int b,
                             input logic [15:0] exp);
      logic [4:0] idx;
      idx = two ? 5'h04 : 5'h03;
      pulse(two, b);
      check("svc port", two ? service_fault_two : service_fault_one, exp);
      rd_chk(idx, exp, "svc flag set");
      rd_chk(idx, 16'h0000, "svc flag clear");
   endtask

   task automatic done_pulse(input logic fail);
      @(negedge core_clk);
      supply_self_test_done = 1'b1;
      supply_self_test_fail = fail;
      @(negedge core_clk);
      supply_self_test_done = 1'b0;
      supply_self_test_fail = 1'b0;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      rd_chk(5'h03, 16'h0200, "svc one reset");
      rd_chk(5'h03, 16'h0000, "svc one read");
      rd_chk(5'h04, 16'h0000, "svc two reset");
      rd_chk(5'h01, 16'h0000, "selftest reset");
      rd_chk(5'h05, 16'hC5DF, "mask one reset");
      rd_chk(5'h06, 16'h409F, "mask two reset");
      rd_chk(5'h02, 16'h0000, "unmapped read");
   endtask

   task automatic t_pins();
      @(negedge core_clk);
      driver_enable_input = 1'b1;
      hw_mode             = 1'b1;
      channel_input_pin   = 4'b0101;
      fault_output_pin_n  = 1'b0;
      nvm_busy            = 1'b1;
      safety_path_echo    = 1'b0;
      repeat (8) @(negedge core_clk);
      rd_chk(5'h00, 16'h0115, "echo busy");
      driver_enable_input  = 1'b0;
      channel_input_pin    = 4'b1010;
      external_reset_pin_n = 1'b0;
      fault_output_pin_n   = 1'b1;
      nvm_busy             = 1'b0;
      safety_path_echo     = 1'b1;
      repeat (8) @(negedge core_clk);
      ftp_host_model_inst.wr(5'h00, 16'hFFFF);
      rd_chk(5'h00, 16'h00EA, "echo swapped");
      hw_mode           = 1'b0;
      channel_input_pin = 4'b1111;
      repeat (8) @(negedge core_clk);
      rd_chk(5'h00, 16'h00FE, "echo sw mode");
   endtask

   task automatic t_svc_one();
      int bits[11] = '{15, 14, 10, 7, 6, 5, 4, 3, 2, 1, 0};
      foreach (bits[i]) begin
         flag_cycle(1'b0, bits[i], 16'h0001 << bits[i]);
      end
      flag_cycle(1'b0, 13, 16'h0000);
      @(negedge core_clk);
      trim_crc_error = 1'b1;
      rd_chk(5'h03, 16'h0100, "trim crc");
      rd_chk(5'h03, 16'h0100, "trim crc kept");
      trim_crc_error = 1'b0;
      rd_chk(5'h03, 16'h0000, "trim crc gone");
   endtask

   task automatic t_svc_two();
      int bits[8] = '{15, 7, 6, 4, 3, 2, 1, 0};
      foreach (bits[i]) begin
         flag_cycle(1'b1, bits[i], 16'h0001 << bits[i]);
      end
      flag_cycle(1'b1, 5, 16'h0000);
      @(negedge core_clk);
      clamp_monitor = 1'b1;
      rd_chk(5'h04, 16'h4000, "clamp");
      rd_chk(5'h04, 16'h4000, "clamp kept");
      clamp_monitor = 1'b0;
   endtask

   task automatic t_selftest();
      ftp_host_model_inst.wr(5'h01, 16'hFFFF);
      check("test run", {15'h0000, supply_self_test}, 16'h0001);
      rd_chk(5'h01, 16'h0001, "test bit");
      // Zero write must not abort
      ftp_host_model_inst.wr(5'h01, 16'h0000);
      check("test no abort", {15'h0000, supply_self_test}, 16'h0001);
      done_pulse(1'b0);
      check("test done", {15'h0000, supply_self_test}, 16'h0000);
      rd_chk(5'h01, 16'h0000, "test bit done");
      rd_chk(5'h03, 16'h0000, "test pass");
      done_pulse(1'b1);
      rd_chk(5'h03, 16'h0000, "idle done");
      ftp_host_model_inst.wr(5'h01, 16'h0001);
      done_pulse(1'b1);
      check("test fail end", {15'h0000, supply_self_test}, 16'h0000);
      rd_chk(5'h03, 16'h0200, "test fail latch");
   endtask

   task automatic t_masks();
      ftp_host_model_inst.wr(5'h05, 16'h0000);
      check("mask one port", service_fault_mask_one, 16'h0000);
      ftp_host_model_inst.wr(5'h05, 16'hFFFF);
      rd_chk(5'h05, 16'hC5DF, "mask one used");
      ftp_host_model_inst.wr(5'h06, 16'h0000);
      check("mask two port", service_fault_mask_two, 16'h0000);
      ftp_host_model_inst.wr(5'h06, 16'hFFFF);
      rd_chk(5'h06, 16'h409F, "mask two used");
      ftp_host_model_inst.wr(5'h03, 16'hFFFF);
      ftp_host_model_inst.wr(5'h04, 16'hFFFF);
      rd_chk(5'h03, 16'h0000, "svc one ro");
      rd_chk(5'h04, 16'h0000, "svc two ro");
      link_fault_flags = 16'hFFFF;
      rd_chk(5'h1D, 16'h1E00, "link flags");
   endtask

   task automatic t_set_wins();
      @(negedge core_clk);
      svc_one_event[0] = 1'b1;
      rd_chk(5'h03, 16'h0001, "set during read");
      svc_one_event = 16'h0000;
      rd_chk(5'h03, 16'h0001, "set kept");
      rd_chk(5'h03, 16'h0000, "set cleared");
   endtask

   // ----------------------------------------------------------------
   // Closing and control
   // ----------------------------------------------------------------
   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Run needs under 1000 cycles; five times that
   initial begin
      #(8 * 5000);
      n_mismatch++;
      $display("[ERR] watchdog expected finish seen timeout");
      summarize();
   end

   initial begin
      repeat (10) @(negedge core_clk);
      rst_n = 1'b1;
      t_reset();
      t_pins();
      t_svc_one();
      t_svc_two();
      t_selftest();
      t_masks();
      t_set_wins();
      summarize();
   end
endmodule
